// [logic/pcs_defines.svh]
// Purpose: offsets, field positions and reset values of the config space
// Assumes: byte offsets as seen by a configuration cycle, dword aligned
// Notes: included by bare name; constants only
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ============================================================
// register offsets
`define PCS_OFF_IDENT 8'h00
`define PCS_OFF_CS 8'h04
`define PCS_OFF_REV 8'h08
`define PCS_OFF_LAT 8'h0c
`define PCS_OFF_IOA 8'h10
`define PCS_OFF_MA 8'h14
`define PCS_OFF_SID 8'h2c
`define PCS_OFF_ROM 8'h30
`define PCS_OFF_CAP 8'h34
`define PCS_OFF_INT 8'h3c
`define PCS_OFF_PM_CAP 8'h40
`define PCS_OFF_PMCS 8'h44

// ============================================================
// command and status layout
`define PCS_CS_RESET 32'h02900000
`define PCS_CMD_MASK 16'h0347
`define PCS_BIT_PARE 31
`define PCS_BIT_SYSE 30
`define PCS_BIT_RXMA 29
`define PCS_BIT_RXTA 28
`define PCS_BIT_TXTA 27
`define PCS_TIM_MSB 26
`define PCS_TIM_LSB 25
`define PCS_TIM_VAL 2'b01
`define PCS_BIT_DPAR 24
`define PCS_BIT_FBB 23
`define PCS_BIT_NCAP 20
`define PCS_STAT_W 6

// ============================================================
// writable registers
`define PCS_RW_RESET 32'h00000000
`define PCS_RW_MASK 32'hffffffff

`endif

// [logic/pcs_pkg.sv]
// Purpose: types shared by the config space bank, the host model and the bench
// Assumes: pcs_defines.svh holds the numbers
// Notes: request and event carriers are packed structs
package pcs_pkg;

  // ============================================================
  // carriers
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcs_req_t;

  typedef struct packed {
    logic detected_parity_error_flag;
    logic signaled_system_error_flag;
    logic received_master_abort_flag;
    logic received_target_abort_flag;
    logic sent_target_abort_flag;
    logic data_parity_detected_flag;
  } pcs_evt_t;

  // ============================================================
  // decoded register select
  typedef enum logic [3:0] {
    pcs_sel_none = 4'h0,
    pcs_sel_ident = 4'h1,
    pcs_sel_cs = 4'h2,
    pcs_sel_rev = 4'h3,
    pcs_sel_lat = 4'h4,
    pcs_sel_ioa = 4'h5,
    pcs_sel_ma = 4'h6,
    pcs_sel_sid = 4'h7,
    pcs_sel_rom = 4'h8,
    pcs_sel_cap = 4'h9,
    pcs_sel_int = 4'ha,
    pcs_sel_pm_cap = 4'hb,
    pcs_sel_pmcs = 4'hc
  } pcs_sel_t;

endpackage

// [logic/pcs_status_flags.sv]
// Purpose: sticky status flags, set by events, cleared by writing ones
// Assumes: set and clr are from logic on the same clock
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
module pcs_status_flags #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);

  // ============================================================
  // flag state
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  always_comb begin
    flags_d = flags_q;
    if (ce) begin
      // ones clear, zeros keep, set overrides the clear
      flags_d = (flags_q & ~clr) | set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

  // ============================================================
  // checks
  property p_set_wins;
    @(posedge clk) disable iff (rst)
    ce |=> ((flags & $past(set)) == $past(set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("status event lost");

  property p_one_clears;
    @(posedge clk) disable iff (rst)
    (ce && ((clr & ~set) != '0)) |=> ((flags & $past(clr & ~set)) == '0);
  endproperty
  a_one_clears: assert property (p_one_clears)
    else $error("status bit not cleared by a one");

  property p_zero_keeps;
    @(posedge clk) disable iff (rst)
    1'b1 |=> (($past(flags & ~clr) & ~flags) == '0);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("status bit lost without a clearing one");

endmodule

// [logic/pcs_config_space.sv]
// Purpose: configuration register bank reached by configuration cycles
// Assumes: pci target logic presents one dword access per req_valid
// Notes: answer one cycle later; soft reset never touches this bank
//
// Contract
// - software reset leaves every config register unchanged
// - hardware reset loads every config register with its reset value
// - unused locations ignore writes and read zero
// - 18h-28h, 38h and 48h-ffh are reserved, reading zero
// - read-only identity register: device code high, vendor code low
// - command/status: status in upper half, command in lower half
// - writing a one to a status bit clears it
// - select-timing field always reads 01, medium timing
// - parity, system error, master/target abort flags set by events
// - revision, latency, subsystem, capability, pm capability read-only
// - io base, memory base, rom, interrupt, pm control writable
// - data parity detected has its own status bit 24
`timescale 1ns/1ns
`include "pcs_defines.svh"
module pcs_config_space #(
  parameter logic [15:0] DEVICE_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] VENDOR_CODE = 16'h5678, // arbitrary value
  parameter logic [31:0] REVISION_VAL = 32'h00000000,
  parameter logic [31:0] LATENCY_VAL = 32'h00000000,
  parameter logic [31:0] SUBSYS_VAL = 32'h00000000,
  parameter logic [31:0] PM_CAP_VAL = 32'h00000000,
  parameter logic NEW_CAP_EN = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic soft_rst,
  input wire logic req_valid,
  input wire pcs_pkg::pcs_req_t req,
  output logic ack,
  output logic [31:0] rdata,
  input wire pcs_pkg::pcs_evt_t events,
  output logic [15:0] cmd_word,
  output logic [31:0] io_base,
  output logic [31:0] mem_base,
  output logic [31:0] rom_cfg,
  output logic [31:0] int_sel,
  output logic [31:0] pm_ctl_stat
);
  import pcs_pkg::*;

  // ============================================================
  // helpers
  function automatic pcs_sel_t decode(input logic [7:0] addr);
    logic [7:0] wa;
    wa = {addr[7:2], 2'b00};
    // reserved holes fall through to none
    if (wa == `PCS_OFF_IDENT) begin
      decode = pcs_sel_ident;
    end else if (wa == `PCS_OFF_CS) begin
      decode = pcs_sel_cs;
    end else if (wa == `PCS_OFF_REV) begin
      decode = pcs_sel_rev;
    end else if (wa == `PCS_OFF_LAT) begin
      decode = pcs_sel_lat;
    end else if (wa == `PCS_OFF_IOA) begin
      decode = pcs_sel_ioa;
    end else if (wa == `PCS_OFF_MA) begin
      decode = pcs_sel_ma;
    end else if (wa == `PCS_OFF_SID) begin
      decode = pcs_sel_sid;
    end else if (wa == `PCS_OFF_ROM) begin
      decode = pcs_sel_rom;
    end else if (wa == `PCS_OFF_CAP) begin
      decode = pcs_sel_cap;
    end else if (wa == `PCS_OFF_INT) begin
      decode = pcs_sel_int;
    end else if (wa == `PCS_OFF_PM_CAP) begin
      decode = pcs_sel_pm_cap;
    end else if (wa == `PCS_OFF_PMCS) begin
      decode = pcs_sel_pmcs;
    end else begin
      decode = pcs_sel_none;
    end
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be,
                                           input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    merge_be = (old & ~bm) | (wd & bm);
  endfunction

  // ============================================================
  // access decode
  pcs_sel_t sel;
  logic take;
  logic wr;

  assign sel = decode(req.addr);
  assign take = req_valid && ce;
  assign wr = take && req.we;

  // ============================================================
  // status flags
  logic [`PCS_STAT_W-1:0] stat_set;
  logic [`PCS_STAT_W-1:0] stat_clr;
  logic [`PCS_STAT_W-1:0] stat_flags;

  assign stat_set = events;

  always_comb begin
    stat_clr = '0;
    if (wr && sel == pcs_sel_cs && req.be[3]) begin
      stat_clr = {req.wdata[`PCS_BIT_PARE], req.wdata[`PCS_BIT_SYSE],
                  req.wdata[`PCS_BIT_RXMA], req.wdata[`PCS_BIT_RXTA],
                  req.wdata[`PCS_BIT_TXTA], req.wdata[`PCS_BIT_DPAR]};
    end
  end

  pcs_status_flags #(
    .W(`PCS_STAT_W)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set(stat_set),
    .clr(stat_clr),
    .flags(stat_flags)
  );

  // ============================================================
  // writable registers
  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [31:0] ioa_q;
  logic [31:0] ioa_d;
  logic [31:0] ma_q;
  logic [31:0] ma_d;
  logic [31:0] rom_q;
  logic [31:0] rom_d;
  logic [31:0] int_q;
  logic [31:0] int_d;
  logic [31:0] pmcs_q;
  logic [31:0] pmcs_d;
  logic [31:0] cmd_wide;

  // soft_rst feeds no register on purpose: only rst may clear the bank
  always_comb begin
    cmd_d = cmd_q;
    ioa_d = ioa_q;
    ma_d = ma_q;
    rom_d = rom_q;
    int_d = int_q;
    pmcs_d = pmcs_q;
    cmd_wide = merge_be({16'h0000, cmd_q}, req.wdata, req.be,
                        {16'h0000, `PCS_CMD_MASK});
    if (wr) begin
      if (sel == pcs_sel_cs) begin
        cmd_d = cmd_wide[15:0];
      end else if (sel == pcs_sel_ioa) begin
        ioa_d = merge_be(ioa_q, req.wdata, req.be, `PCS_RW_MASK);
      end else if (sel == pcs_sel_ma) begin
        ma_d = merge_be(ma_q, req.wdata, req.be, `PCS_RW_MASK);
      end else if (sel == pcs_sel_rom) begin
        rom_d = merge_be(rom_q, req.wdata, req.be, `PCS_RW_MASK);
      end else if (sel == pcs_sel_int) begin
        int_d = merge_be(int_q, req.wdata, req.be, `PCS_RW_MASK);
      end else if (sel == pcs_sel_pmcs && NEW_CAP_EN) begin
        pmcs_d = merge_be(pmcs_q, req.wdata, req.be, `PCS_RW_MASK);
      end
      // read-only and unused locations drop the write
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= 16'(`PCS_CS_RESET);
      ioa_q <= `PCS_RW_RESET;
      ma_q <= `PCS_RW_RESET;
      rom_q <= `PCS_RW_RESET;
      int_q <= `PCS_RW_RESET;
      pmcs_q <= `PCS_RW_RESET;
    end else begin
      cmd_q <= cmd_d;
      ioa_q <= ioa_d;
      ma_q <= ma_d;
      rom_q <= rom_d;
      int_q <= int_d;
      pmcs_q <= pmcs_d;
    end
  end

  // ============================================================
  // read path
  logic [31:0] cs_word;
  logic [31:0] rd_val;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    cs_word = 32'h00000000;
    cs_word[`PCS_BIT_PARE] = stat_flags[5];
    cs_word[`PCS_BIT_SYSE] = stat_flags[4];
    cs_word[`PCS_BIT_RXMA] = stat_flags[3];
    cs_word[`PCS_BIT_RXTA] = stat_flags[2];
    cs_word[`PCS_BIT_TXTA] = stat_flags[1];
    cs_word[`PCS_TIM_MSB:`PCS_TIM_LSB] = `PCS_TIM_VAL;
    cs_word[`PCS_BIT_DPAR] = stat_flags[0];
    cs_word[`PCS_BIT_FBB] = 1'b1;
    cs_word[`PCS_BIT_NCAP] = NEW_CAP_EN;
    cs_word[15:0] = cmd_q;
  end

  always_comb begin
    rd_val = 32'h00000000;
    case (sel)
      pcs_sel_ident: rd_val = {DEVICE_CODE, VENDOR_CODE};
      pcs_sel_cs: rd_val = cs_word;
      pcs_sel_rev: rd_val = REVISION_VAL;
      pcs_sel_lat: rd_val = LATENCY_VAL;
      pcs_sel_ioa: rd_val = ioa_q;
      pcs_sel_ma: rd_val = ma_q;
      pcs_sel_sid: rd_val = SUBSYS_VAL;
      pcs_sel_rom: rd_val = rom_q;
      pcs_sel_int: rd_val = int_q;
      // capabilities vanish when new capabilities are disabled
      pcs_sel_cap: begin
        rd_val = NEW_CAP_EN ? {24'h000000, `PCS_OFF_PM_CAP} : 32'h0;
      end
      pcs_sel_pm_cap: rd_val = NEW_CAP_EN ? PM_CAP_VAL : 32'h0;
      pcs_sel_pmcs: rd_val = NEW_CAP_EN ? pmcs_q : 32'h0;
      default: rd_val = 32'h00000000;
    endcase
  end

  always_comb begin
    ack_d = ack_q;
    rdata_d = rdata_q;
    if (ce) begin
      ack_d = req_valid;
      // writes answer zero so stale data never looks like a read
      rdata_d = (req_valid && !req.we) ? rd_val : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign ack = ack_q;
  assign rdata = rdata_q;
  assign cmd_word = cmd_q;
  assign io_base = ioa_q;
  assign mem_base = ma_q;
  assign rom_cfg = rom_q;
  assign int_sel = int_q;
  assign pm_ctl_stat = pmcs_q;

  // ============================================================
  // checks
  logic [191:0] regs_all;
  assign regs_all = {cmd_q, 16'h0000, ioa_q, ma_q, rom_q, int_q, pmcs_q};

  property p_soft_keeps;
    @(posedge clk) disable iff (rst)
    (soft_rst && !wr) |=> (regs_all == $past(regs_all));
  endproperty
  a_soft_keeps: assert property (p_soft_keeps)
    else $error("soft reset changed a config register");

  property p_hard_reset;
    @(posedge clk)
    rst |=> (io_base == `PCS_RW_RESET && pm_ctl_stat == `PCS_RW_RESET
             && cmd_word == 16'h0000 && !ack);
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset value not loaded");

  property p_unused_read;
    @(posedge clk) disable iff (rst)
    (take && !req.we && sel == pcs_sel_none) |=> (ack && rdata == 32'h0);
  endproperty
  a_unused_read: assert property (p_unused_read)
    else $error("unused location read nonzero");

  property p_drop_write;
    @(posedge clk) disable iff (rst)
    (wr && (sel == pcs_sel_none || sel == pcs_sel_rev || sel == pcs_sel_lat
            || sel == pcs_sel_sid || sel == pcs_sel_cap
            || sel == pcs_sel_pm_cap || sel == pcs_sel_ident))
      |=> (regs_all == $past(regs_all));
  endproperty
  a_drop_write: assert property (p_drop_write)
    else $error("write to read-only or unused location stored");

  property p_ident;
    @(posedge clk) disable iff (rst)
    (take && !req.we && sel == pcs_sel_ident)
      |=> (rdata == {DEVICE_CODE, VENDOR_CODE});
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity register read wrong");

  property p_timing;
    @(posedge clk) disable iff (rst)
    (take && !req.we && sel == pcs_sel_cs)
      |=> (rdata[`PCS_TIM_MSB:`PCS_TIM_LSB] == `PCS_TIM_VAL
           && rdata[`PCS_BIT_FBB]);
  endproperty
  a_timing: assert property (p_timing)
    else $error("select timing field moved");

  property p_rw_store;
    @(posedge clk) disable iff (rst)
    (wr && sel == pcs_sel_ioa && req.be == 4'hf)
      |=> (io_base == $past(req.wdata));
  endproperty
  a_rw_store: assert property (p_rw_store)
    else $error("io base write not stored");

  property p_cmd_split;
    @(posedge clk) disable iff (rst)
    (wr && sel == pcs_sel_cs && req.be == 4'hf)
      |=> (cmd_word == ($past(req.wdata[15:0]) & `PCS_CMD_MASK));
  endproperty
  a_cmd_split: assert property (p_cmd_split)
    else $error("command half not written from low half");

  property p_par_seen;
    @(posedge clk) disable iff (rst)
    (ce && events.data_parity_detected_flag) |=> cs_word[`PCS_BIT_DPAR];
  endproperty
  a_par_seen: assert property (p_par_seen)
    else $error("data parity detected not reported");

endmodule

// [sim/pcs_host_model.sv]
// Purpose: host bridge side issuing configuration cycles
// Assumes: requests change at the falling edge, held over the taking edge
// Notes: a released bus shows flipped fields, never the last request
`timescale 1ns/1ns
module pcs_host_model (
  input wire logic clk,
  output logic req_valid,
  output pcs_pkg::pcs_req_t req
);
  import pcs_pkg::*;

  // ============================================================
  // drive
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // one dword per call; back to back calls give one request a cycle
  task automatic issue(input logic we, input logic [7:0] addr,
                       input logic [3:0] be, input logic [31:0] wd);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{we: we, addr: addr, be: be, wdata: wd};
  endtask

  // stale fields inverted so a dropped valid cannot pass unnoticed
  task automatic release_bus();
    @(negedge clk);
    req_valid = 1'b0;
    req = ~req;
  endtask
endmodule

// [sim/tb.sv]
// Purpose: self-checking bench for the configuration register bank
// Assumes: ack one cycle after a taken request, ce high but one window
// Notes: expectations queued by the driver, popped when ack shows
`timescale 1ns/1ns
`include "pcs_defines.svh"
module tb;
  import pcs_pkg::*;

  // ============================================================
  // setup
  localparam logic [15:0] DEV = 16'h4a5c; // arbitrary value
  localparam logic [15:0] VEN = 16'h3e71; // arbitrary value
  localparam logic [31:0] REV = 32'h020000a3;
  localparam logic [31:0] LAT = 32'h0000f840;
  localparam logic [31:0] SID = 32'h5d2e6b19;
  localparam logic [31:0] PMC = 32'h7e025801;
  localparam logic [31:0] STM = 32'hf9000000;
  logic clk, rst, ce, soft_rst, req_valid, ack;
  pcs_req_t req;
  pcs_evt_t events;
  logic [31:0] rdata, io_base, mem_base, rom_cfg, int_sel, pm_ctl_stat;
  logic [15:0] cmd_word;
  logic [31:0] exp_q[$];
  logic [31:0] rw_m [0:4];
  logic [31:0] st_m;
  logic [15:0] cmd_m;
  int n_mismatch = 0;
  int compares = 0;

  pcs_config_space #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEN),
    .REVISION_VAL(REV), .LATENCY_VAL(LAT), .SUBSYS_VAL(SID),
    .PM_CAP_VAL(PMC), .NEW_CAP_EN(1'b1)) DUT (
    .clk(clk), .rst(rst), .ce(ce), .soft_rst(soft_rst),
    .req_valid(req_valid), .req(req), .ack(ack), .rdata(rdata),
    .events(events), .cmd_word(cmd_word), .io_base(io_base),
    .mem_base(mem_base), .rom_cfg(rom_cfg), .int_sel(int_sel),
    .pm_ctl_stat(pm_ctl_stat));
  pcs_host_model host (.clk(clk), .req_valid(req_valid), .req(req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ============================================================
  // reference model
  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a & 8'hfc)
      `PCS_OFF_IDENT: return {DEV, VEN};
      `PCS_OFF_CS: return `PCS_CS_RESET | st_m | {16'h0, cmd_m};
      `PCS_OFF_REV: return REV;
      `PCS_OFF_LAT: return LAT;
      `PCS_OFF_SID: return SID;
      `PCS_OFF_CAP: return 32'h00000040;
      `PCS_OFF_PM_CAP: return PMC;
      `PCS_OFF_IOA: return rw_m[0];
      `PCS_OFF_MA: return rw_m[1];
      `PCS_OFF_ROM: return rw_m[2];
      `PCS_OFF_INT: return rw_m[3];
      `PCS_OFF_PMCS: return rw_m[4];
      default: return 32'h0;
    endcase
  endfunction

  task automatic upd(input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    logic [31:0] bm;
    int k;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    k = -1;
    case (a & 8'hfc)
      `PCS_OFF_IOA: k = 0;
      `PCS_OFF_MA: k = 1;
      `PCS_OFF_ROM: k = 2;
      `PCS_OFF_INT: k = 3;
      `PCS_OFF_PMCS: k = 4;
      `PCS_OFF_CS: begin
        cmd_m = (cmd_m & ~bm[15:0]) | (wd[15:0] & bm[15:0] & `PCS_CMD_MASK);
        st_m = st_m & ~(wd & bm & STM);
      end
      default: k = -1;
    endcase
    if (k >= 0) begin
      rw_m[k] = (rw_m[k] & ~bm) | (wd & bm);
    end
  endtask

  // ============================================================
  // checking
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) check("ack", 32'h1, 32'h0);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end

  task automatic rd(input logic [7:0] a);
    host.issue(1'b0, a, 4'hf, $urandom);
    exp_q.push_back(exp_of(a));
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] wd);
    host.issue(1'b1, a, be, wd);
    upd(a, be, wd);
    exp_q.push_back(32'h0);
  endtask

  // idle the bus, let answers land, then compare the register ports
  task automatic drain();
    host.release_bus();
    repeat (2) @(negedge clk);
    check("pending", 32'(exp_q.size()), 32'h0);
    check("io_base", io_base, rw_m[0]);
    check("mem_base", mem_base, rw_m[1]);
    check("rom_cfg", rom_cfg, rw_m[2]);
    check("int_sel", int_sel, rw_m[3]);
    check("pm_ctl_stat", pm_ctl_stat, rw_m[4]);
    check("cmd_word", {16'h0, cmd_word}, {16'h0, cmd_m});
  endtask

  task automatic read_map();
    for (int a = 0; a <= 8'h48; a += 4) rd(8'(a));
  endtask

  task automatic hard_reset();
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 5; k++) rw_m[k] = 32'h0;
    cmd_m = 16'h0;
    st_m = 32'h0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ============================================================
  // tests
  initial begin
    #1000000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    soft_rst = 1'b0;
    events = '0;
    void'($urandom(32'h1676));
    hard_reset();
    drain();
    read_map();
    // every offset, random lanes, low address bits ignored
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 256; a += 4) begin
        wr(8'(a) | 8'($urandom % 4), 4'($urandom), $urandom);
        rd(8'(a));
      end
    end
    drain();
    // each status source: set, survive a zero write, clear by one
    for (int i = 0; i < `PCS_STAT_W; i++) begin
      events = 6'(1 << i);
      st_m[(i == 0) ? `PCS_BIT_DPAR : 26 + i] = 1'b1;
      rd(`PCS_OFF_CS);
      events = '0;
      wr(`PCS_OFF_CS, 4'h8, 32'h0);
      rd(`PCS_OFF_CS);
      wr(`PCS_OFF_CS, 4'h8, STM);
      rd(`PCS_OFF_CS);
    end
    // an event in the clearing cycle is kept
    wr(`PCS_OFF_CS, 4'h8, STM);
    events.received_target_abort_flag = 1'b1;
    st_m[`PCS_BIT_RXTA] = 1'b1;
    rd(`PCS_OFF_CS);
    events = '0;
    rd(`PCS_OFF_CS);
    for (int a = 8'h10; a <= 8'h44; a += 4) wr(8'(a), 4'hf, $urandom);
    soft_rst = 1'b1;
    read_map();
    soft_rst = 1'b0;
    drain();
    // ce low: a write and every event must be ignored, no answer given
    ce = 1'b0;
    host.issue(1'b1, `PCS_OFF_IOA, 4'hf, $urandom);
    events = '1;
    host.release_bus();
    events = '0;
    ce = 1'b1;
    rd(`PCS_OFF_CS);
    drain();
    hard_reset();
    drain();
    read_map();
    drain();
    complete_run();
  end
endmodule
